// *** hdl/ssc_cfg.svh ***
// Soft slicer configuration: field positions, limits, host map offsets.
// Assumes inclusion by bare name from the package and both ends.
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// Local header word
`define SSC_HDR_LEN_LSB 0
`define SSC_HDR_LEN_W 7
// Mode word fields (LSB positions)
`define SSC_ROW_IDX_LSB 26
`define SSC_PHYS_CH_LSB 23
`define SSC_NUM_SLOTS_LSB 20
`define SSC_FRAME_SEL_BIT 19
`define SSC_BMAT_LSB 12
`define SSC_QFMT_LSB 10
`define SSC_COL_SEL_LSB 8
`define SSC_PACK_BIT 7
`define SSC_MOD_LSB 4
`define SSC_DESCR_BIT 3
`define SSC_SWAP_BIT 2
`define SSC_SPLIT_BIT 1
`define SSC_TDD_BIT 0
// Control-info length word
`define SSC_ACK_LSB 16
`define SSC_RANK_LSB 0
`define SSC_CIL_MASK 32'h3FFF3FFF
// Slot words
`define SSC_UNIT_LSB 16
`define SSC_SIZE_LSB 0
`define SSC_SLOT_MASK 32'hFFFF0FFF
// Limits
`define SSC_ROW_IDX_MAX 6'h22
`define SSC_MAX_SLOTS 3'h6
`define SSC_MAX_SLOT_SYMS 12'hBF8
`define SSC_UNIT_MAX_QPSK 16'h3FFF
`define SSC_UNIT_MAX_16QAM 16'h2AAA
`define SSC_UNIT_MAX_64QAM 16'h1249
`define SSC_MIN_COLS 4'h9
`define SSC_RB_SUBCARRIERS 16'h000C
`define SSC_HDR_WORDS 7'h06
// Soft bit shaping
`define SSC_LANES 5'h10
`define SSC_Q_SHIFT 4'h8
`define SSC_SB_MAX 8'h7F
`define SSC_SB_MIN 8'h80
`define SSC_ACK_FILL 8'h7F
`define SSC_LFSR_SEED 15'h7FFF
// Host register offsets and reset values
`define SSC_OFS_MODE 8'h00
`define SSC_OFS_CIL 8'h04
`define SSC_OFS_SLOT0 8'h08
`define SSC_OFS_CTRL 8'h18
`define SSC_OFS_SYM 8'h1C
`define SSC_OFS_SYM_LAST 8'h20
`define SSC_OFS_STATUS 8'h24
`define SSC_MODE_RESET 32'h00000018
`define SSC_CTRL_GO_BIT 0
`define SSC_CTRL_DEBUG_BIT 1

`endif

// *** hdl/ssc_dev.sv ***
// Soft slicer end: parses the configuration header, slices symbols,
// packs 8-bit soft bits sixteen to a 128-bit word.
// Assumes the engine keeps the header word order and set limits.
//
// Functional notes
// - Local header low seven bits count following words
// - Row index bits 31-26 selects row count
// - Two row tables, dual entries double single
// - FDD channel count and frame interval bit
// - Slot count from bits 22-20, six maximum
// - Column select gives nine to twelve columns
// - TDD slots 128-bit aligned unless packing set
// - Modulation codes zero to five, six-seven invalid
// - LTE descrambling follows enable bit, else ignored
// - Engine sets descrambler enable for normal LTE
// - IQ swap bit exchanges I and Q
// - Swap leaves FDD PAM levels untouched
// - LTE split bit selects two-layer processing
// - WCDMA bit zero picks FDD or TD-SCDMA
// - Overwrite acknowledgement LLRs, count bits 29-16
// - Puncture rank LLRs, count bits 13-0
// - Slot word top half is unit value
// - Slot word low twelve bits symbol count
// - Engine computes B-matrix index from row table
// - Eight-bit soft bits, sixteen per word
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_dev (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  ssc_if.dev link,
  input wire ssc_pkg::ssc_std_type i_radio_std,
  output logic o_cfg_valid,
  output logic [11:0] o_row_count,
  output logic [3:0] o_col_count,
  output logic [2:0] o_phys_ch,
  output logic o_frame_10ms,
  output logic [2:0] o_num_slots,
  output ssc_pkg::ssc_mod_type o_mod,
  output logic o_mod_err,
  output logic o_descr_on,
  output logic o_split,
  output logic o_tdd_sel,
  output logic [1:0] o_q_format,
  output logic [13:0] o_ackn_llr_count,
  output logic [13:0] o_rank_llr_count,
  output logic [15:0] o_slot_unit,
  output logic [11:0] o_slot_syms,
  output logic o_sb_valid,
  output logic [127:0] o_sb_data,
  output logic o_sb_last
);
  ssc_pkg::ssc_state_type state;
  logic [6:0] hdr_left;
  logic [2:0] hdr_idx;
  logic [31:0] slicer_mode_word;
  logic [31:0] control_info_length_word;
  logic [31:0] slot_word [0:3];
  logic [2:0] slot_idx;
  logic [11:0] slot_sym;
  logic [14:0] llr_idx;
  logic [4:0] lane;
  logic [127:0] acc;
  logic [14:0] lfsr;

  // Mode word decode
  wire [5:0] row_count_index = slicer_mode_word[`SSC_ROW_IDX_LSB +: 6];
  wire [1:0] column_count_sel = slicer_mode_word[`SSC_COL_SEL_LSB +: 2];
  wire pack_on = slicer_mode_word[`SSC_PACK_BIT];
  wire descr_bit = slicer_mode_word[`SSC_DESCR_BIT];
  wire swap_bit = slicer_mode_word[`SSC_SWAP_BIT];
  wire split_bit = slicer_mode_word[`SSC_SPLIT_BIT];
  wire tdd_bit = slicer_mode_word[`SSC_TDD_BIT];
  wire is_lte = (i_radio_std == ssc_pkg::SSC_STD_LTE);
  wire is_wcdma = (i_radio_std == ssc_pkg::SSC_STD_WCDMA);
  wire is_fdd = is_wcdma && !tdd_bit;
  wire is_tdd = is_wcdma && tdd_bit;
  wire split_on = is_lte && split_bit;
  wire descr_on = is_lte && descr_bit;
  wire swap_on = swap_bit && !is_fdd;
  wire [1:0] q_format = slicer_mode_word[`SSC_QFMT_LSB +: 2];
  wire ssc_pkg::ssc_mod_type mod_sel =
    ssc_pkg::ssc_mod_type'(slicer_mode_word[`SSC_MOD_LSB +: 3]);
  wire mod_err = mod_sel[2] && mod_sel[1];
  wire real_only = (mod_sel == ssc_pkg::SSC_MOD_BPSK) ||
    (mod_sel == ssc_pkg::SSC_MOD_PAM4) || is_fdd;

  // Row count lookup; split entries are twice the single ones
  wire row_ok = (row_count_index <= `SSC_ROW_IDX_MAX);
  wire [6:0] prb = row_ok ? ssc_pkg::SSC_PRB_TBL[row_count_index] : 7'h00;
  wire [11:0] row_single = 12'(12'(prb) * 12'(`SSC_RB_SUBCARRIERS));
  wire [11:0] row_count = split_on ? {row_single[10:0], 1'b0} : row_single;

  wire [13:0] ackn_llr_count =
    control_info_length_word[`SSC_ACK_LSB +: 14];
  wire [13:0] rank_llr_count =
    control_info_length_word[`SSC_RANK_LSB +: 14];
  wire [31:0] cur_slot = slot_word[slot_idx[1:0]];
  wire [15:0] slot_unit = cur_slot[`SSC_UNIT_LSB +: 16];
  wire [11:0] slot_syms = cur_slot[`SSC_SIZE_LSB +: 12];

  // Symbol slicing
  wire take = link.valid && (state == ssc_pkg::SSC_ST_SYM);
  wire [15:0] comp_a = swap_on ? link.data[31:16] : link.data[15:0];
  wire [15:0] comp_b = swap_on ? link.data[15:0] : link.data[31:16];
  wire [3:0] q_shift = 4'(`SSC_Q_SHIFT - {2'b00, q_format});

  function automatic logic [7:0] ssc_sat(input logic [15:0] v,
    input logic [3:0] sh, input logic neg);
    logic signed [15:0] s;
    logic signed [15:0] n;
    s = $signed(v) >>> sh;
    n = neg ? -s : s;
    if (n > 16'sd127) begin
      ssc_sat = `SSC_SB_MAX;
    end else if (n < -16'sd128) begin
      ssc_sat = `SSC_SB_MIN;
    end else begin
      ssc_sat = n[7:0];
    end
  endfunction : ssc_sat

  wire [14:0] ctl_end = 15'(rank_llr_count) + 15'(ackn_llr_count);
  wire punct = is_lte && (llr_idx < 15'(rank_llr_count));
  wire ackn = is_lte && !punct && (llr_idx < ctl_end);
  wire [7:0] raw_a = ssc_sat(comp_a, q_shift, descr_on && lfsr[0]);
  wire [7:0] raw_b = ssc_sat(comp_b, q_shift, descr_on && lfsr[1]);
  wire [7:0] soft_a = punct ? 8'h00 : (ackn ? `SSC_ACK_FILL : raw_a);
  wire [7:0] soft_b = punct ? 8'h00 : (ackn ? `SSC_ACK_FILL : raw_b);
  wire [4:0] step = real_only ? 5'h01 : 5'h02;
  wire [4:0] next_lane = lane + step;
  wire slot_end = is_tdd && (slot_sym + 12'h001 >= slot_syms);
  wire flush = (next_lane >= `SSC_LANES) || link.last ||
    (slot_end && !pack_on);

  logic [127:0] next_acc;
  always_comb begin
    next_acc = acc;
    next_acc[lane[3:0]*8 +: 8] = soft_a;
    if (!real_only && lane < 5'h0F) begin
      next_acc[(lane[3:0] + 4'h1)*8 +: 8] = soft_b;
    end
  end

  assign link.ready = 1'b1;
  assign o_row_count = row_count;
  assign o_col_count = `SSC_MIN_COLS + {2'b00, column_count_sel};
  assign o_phys_ch = slicer_mode_word[`SSC_PHYS_CH_LSB +: 3];
  assign o_frame_10ms = slicer_mode_word[`SSC_FRAME_SEL_BIT];
  assign o_num_slots = slicer_mode_word[`SSC_NUM_SLOTS_LSB +: 3];
  assign o_mod = mod_sel;
  assign o_mod_err = mod_err;
  assign o_descr_on = descr_on;
  assign o_split = split_on;
  assign o_tdd_sel = is_tdd;
  assign o_q_format = q_format;
  assign o_ackn_llr_count = ackn_llr_count;
  assign o_rank_llr_count = rank_llr_count;
  assign o_slot_unit = slot_unit;
  assign o_slot_syms = slot_syms;

  // Header parsing
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ssc_pkg::SSC_ST_IDLE;
      hdr_left <= 7'h00;
      hdr_idx <= 3'h0;
      o_cfg_valid <= 1'b0;
    end else if (link.valid) begin
      case (state)
        ssc_pkg::SSC_ST_IDLE: begin
          hdr_left <= link.data[`SSC_HDR_LEN_LSB +: `SSC_HDR_LEN_W];
          hdr_idx <= 3'h1;
          o_cfg_valid <= (link.data[6:0] == 7'h00);
          state <= (link.data[6:0] == 7'h00) ? ssc_pkg::SSC_ST_SYM :
            ssc_pkg::SSC_ST_HDR;
        end
        ssc_pkg::SSC_ST_HDR: begin
          hdr_left <= hdr_left - 7'h01;
          if (hdr_idx != 3'h7) begin
            hdr_idx <= hdr_idx + 3'h1;
          end
          if (hdr_left == 7'h01) begin
            state <= ssc_pkg::SSC_ST_SYM;
            o_cfg_valid <= 1'b1;
          end
        end
        ssc_pkg::SSC_ST_SYM: begin
          if (link.last) begin
            state <= ssc_pkg::SSC_ST_IDLE;
            o_cfg_valid <= 1'b0;
          end
        end
        default: state <= ssc_pkg::SSC_ST_IDLE;
      endcase
    end
  end

  // Configuration words in header order; later words are skipped
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slicer_mode_word <= 32'h00000000;
      control_info_length_word <= 32'h00000000;
      for (int k = 0; k < 4; k++) begin
        slot_word[k] <= 32'h00000000;
      end
    end else if (link.valid && state == ssc_pkg::SSC_ST_HDR) begin
      case (hdr_idx)
        3'h1: slicer_mode_word <= link.data;
        3'h2: control_info_length_word <= link.data & `SSC_CIL_MASK;
        3'h3, 3'h4, 3'h5, 3'h6:
          slot_word[2'(hdr_idx - 3'h3)] <= link.data & `SSC_SLOT_MASK;
        default: ;
      endcase
    end
  end

  // Slot and LLR position tracking, descrambler sequence
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot_idx <= 3'h0;
      slot_sym <= 12'h000;
      llr_idx <= 15'h0000;
      lfsr <= `SSC_LFSR_SEED;
    end else if (state != ssc_pkg::SSC_ST_SYM) begin
      slot_idx <= 3'h0;
      slot_sym <= 12'h000;
      llr_idx <= 15'h0000;
      lfsr <= `SSC_LFSR_SEED;
    end else if (take) begin
      llr_idx <= (llr_idx == 15'h7FFF) ? llr_idx : llr_idx + 15'h0001;
      lfsr <= {lfsr[12:0], lfsr[14] ^ lfsr[13], lfsr[13] ^ lfsr[12]};
      slot_sym <= slot_end ? 12'h000 : slot_sym + 12'h001;
      if (slot_end && slot_idx != 3'h3) begin
        slot_idx <= slot_idx + 3'h1;
      end
    end
  end

  // Soft-bit packing and output
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lane <= 5'h00;
      acc <= 128'h0;
      o_sb_valid <= 1'b0;
      o_sb_data <= 128'h0;
      o_sb_last <= 1'b0;
    end else begin
      o_sb_valid <= take && flush;
      o_sb_last <= take && link.last;
      if (take && flush) begin
        o_sb_data <= next_acc;
        acc <= 128'h0;
        lane <= 5'h00;
      end else if (take) begin
        acc <= next_acc;
        lane <= next_lane;
      end
    end
  end
endmodule : ssc_dev
`default_nettype wire

// *** hdl/ssc_host.sv ***
// Packet engine end: software fills header registers, then sends the
// header and symbols. Register port: read data one cycle after strobe.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_host (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  ssc_if.eng link,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  logic [31:0] slicer_mode_word;
  logic [31:0] control_info_length_word;
  logic [31:0] slot_word [0:3];
  logic debug_descr;
  logic hdr_busy;
  logic [2:0] hdr_pos;
  logic [15:0] sym_sent;

  wire ssc_pkg::ssc_mod_type mod_sel =
    ssc_pkg::ssc_mod_type'(slicer_mode_word[`SSC_MOD_LSB +: 3]);
  wire [5:0] row_idx = slicer_mode_word[`SSC_ROW_IDX_LSB +: 6];
  wire [6:0] prb = (row_idx <= `SSC_ROW_IDX_MAX) ?
    ssc_pkg::SSC_PRB_TBL[row_idx] : 7'h00;
  wire [1:0] layers = slicer_mode_word[`SSC_SPLIT_BIT] ? 2'h2 : 2'h1;
  logic [3:0] qm;
  logic [15:0] unit_max;
  always_comb begin
    case (mod_sel)
      ssc_pkg::SSC_MOD_QPSK: qm = 4'h2;
      ssc_pkg::SSC_MOD_QAM16: qm = 4'h4;
      ssc_pkg::SSC_MOD_QAM64: qm = 4'h6;
      ssc_pkg::SSC_MOD_QAM256: qm = 4'h8;
      default: qm = 4'h1;
    endcase
    case (mod_sel)
      ssc_pkg::SSC_MOD_QAM16: unit_max = `SSC_UNIT_MAX_16QAM;
      ssc_pkg::SSC_MOD_QAM64: unit_max = `SSC_UNIT_MAX_64QAM;
      default: unit_max = `SSC_UNIT_MAX_QPSK;
    endcase
  end

  // B-matrix index: position of 12*prb*layers*qm in the row table
  wire [15:0] bmat_prod = 16'(16'(prb) * `SSC_RB_SUBCARRIERS *
    16'(layers) * 16'(qm));
  logic [6:0] bmat_idx;
  always_comb begin
    bmat_idx = 7'h00;
    for (int k = 71; k >= 0; k--) begin
      if ({1'b0, ssc_pkg::SSC_ROW_TBL[k]} == bmat_prod) begin
        bmat_idx = 7'(k);
      end
    end
  end

  // Header words as sent: limits enforced, descrambling on unless the CTRL debug bit is set
  wire [2:0] slots_in = slicer_mode_word[`SSC_NUM_SLOTS_LSB +: 3];
  wire [2:0] slots_out = (slots_in > `SSC_MAX_SLOTS) ?
    `SSC_MAX_SLOTS : slots_in;
  logic [31:0] mode_out;
  always_comb begin
    mode_out = slicer_mode_word;
    mode_out[`SSC_NUM_SLOTS_LSB +: 3] = slots_out;
    mode_out[`SSC_BMAT_LSB +: 7] = bmat_idx;
    mode_out[`SSC_DESCR_BIT] = !debug_descr;
  end
  wire [31:0] slot_in = slot_word[2'(hdr_pos - 3'h3)];
  wire [15:0] unit_in = slot_in[`SSC_UNIT_LSB +: 16];
  wire [11:0] size_in = slot_in[`SSC_SIZE_LSB +: 12];
  wire [31:0] slot_out = {(unit_in > unit_max) ? unit_max : unit_in, 4'h0,
    (size_in > `SSC_MAX_SLOT_SYMS) ? `SSC_MAX_SLOT_SYMS : size_in};
  logic [31:0] hdr_word;
  always_comb begin
    case (hdr_pos)
      3'h0: hdr_word = {25'h0, `SSC_HDR_WORDS};
      3'h1: hdr_word = mode_out;
      3'h2: hdr_word = control_info_length_word & `SSC_CIL_MASK;
      default: hdr_word = slot_out;
    endcase
  end

  wire sym_wr = i_wr && !hdr_busy && !(link.valid && !link.ready) &&
    (i_addr == `SSC_OFS_SYM || i_addr == `SSC_OFS_SYM_LAST);
  wire go_wr = i_wr && i_addr == `SSC_OFS_CTRL &&
    i_wdata[`SSC_CTRL_GO_BIT] && !hdr_busy && !link.valid;
  wire [3:0] slot_sel = 4'(i_addr - `SSC_OFS_SLOT0) >> 2;
  wire slot_hit = i_addr >= `SSC_OFS_SLOT0 && i_addr < `SSC_OFS_CTRL &&
    i_addr[1:0] == 2'b00;

  // Configuration registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slicer_mode_word <= `SSC_MODE_RESET;
      control_info_length_word <= 32'h00000000;
      debug_descr <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        slot_word[k] <= 32'h00000000;
      end
    end else if (i_wr) begin
      if (i_addr == `SSC_OFS_MODE) begin
        slicer_mode_word <= i_wdata;
      end
      if (i_addr == `SSC_OFS_CIL) begin
        control_info_length_word <= i_wdata;
      end
      if (i_addr == `SSC_OFS_CTRL) begin
        debug_descr <= i_wdata[`SSC_CTRL_DEBUG_BIT];
      end
      if (slot_hit) begin
        slot_word[slot_sel[1:0]] <= i_wdata;
      end
    end
  end

  // Link driver: header burst, then one symbol per register write
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hdr_busy <= 1'b0;
      hdr_pos <= 3'h0;
      link.valid <= 1'b0;
      link.data <= 32'h00000000;
      link.last <= 1'b0;
      sym_sent <= 16'h0000;
    end else if (hdr_busy) begin
      link.valid <= 1'b1;
      link.data <= hdr_word;
      if (link.ready || !link.valid) begin
        hdr_pos <= hdr_pos + 3'h1;
        hdr_busy <= (hdr_pos != 3'h6);
      end
    end else if (go_wr) begin
      hdr_busy <= 1'b1;
      hdr_pos <= 3'h0;
      sym_sent <= 16'h0000;
    end else if (sym_wr) begin
      link.valid <= 1'b1;
      link.data <= i_wdata;
      link.last <= (i_addr == `SSC_OFS_SYM_LAST);
      sym_sent <= sym_sent + 16'h0001;
    end else if (link.ready) begin
      link.valid <= 1'b0;
      link.last <= 1'b0;
    end
  end

  // Register read port
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `SSC_OFS_MODE: o_rdata <= mode_out;
        `SSC_OFS_CIL: o_rdata <= control_info_length_word;
        `SSC_OFS_CTRL: o_rdata <= {30'h0, debug_descr, 1'b0};
        `SSC_OFS_STATUS: o_rdata <= {sym_sent, 1'b0, bmat_idx, 6'h00,
          link.valid, hdr_busy};
        default: o_rdata <= slot_hit ? slot_word[slot_sel[1:0]] :
          32'h00000000;
      endcase
    end
  end
endmodule : ssc_host
`default_nettype wire

// *** hdl/ssc_if.sv ***
// Header and symbol stream between packet engine and soft slicer.
// Both ends share one clock; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface ssc_if;
  logic valid;
  logic [31:0] data;
  logic last;
  logic ready;
  modport eng (output valid, output data, output last, input ready);
  modport dev (input valid, input data, input last, output ready);
endinterface : ssc_if
`default_nettype wire

// *** hdl/ssc_pkg.sv ***
// Soft slicer types and constant lookup tables.
// Assumes ssc_cfg.svh on the include path.
`default_nettype none
`include "ssc_cfg.svh"
package ssc_pkg;
  typedef enum logic [2:0] {
    SSC_MOD_BPSK = 3'h0,
    SSC_MOD_QPSK = 3'h1,
    SSC_MOD_QAM16 = 3'h2,
    SSC_MOD_QAM64 = 3'h3,
    SSC_MOD_QAM256 = 3'h4,
    SSC_MOD_PAM4 = 3'h5,
    SSC_MOD_BAD6 = 3'h6,
    SSC_MOD_BAD7 = 3'h7
  } ssc_mod_type;

  typedef enum logic [1:0] {
    SSC_STD_LTE = 2'h0,
    SSC_STD_WIMAX = 2'h1,
    SSC_STD_WCDMA = 2'h2,
    SSC_STD_RSVD = 2'h3
  } ssc_std_type;

  typedef enum logic [1:0] {
    SSC_ST_IDLE = 2'h0,
    SSC_ST_HDR = 2'h1,
    SSC_ST_SYM = 2'h2
  } ssc_state_type;

  // Resource blocks per row index, single layer
  localparam logic [6:0] SSC_PRB_TBL [0:34] = '{
    7'd1, 7'd2, 7'd3, 7'd4, 7'd5, 7'd6, 7'd8, 7'd9, 7'd10, 7'd12, 7'd15,
    7'd16, 7'd18, 7'd20, 7'd24, 7'd25, 7'd27, 7'd30, 7'd32, 7'd36, 7'd40,
    7'd45, 7'd48, 7'd50, 7'd54, 7'd60, 7'd64, 7'd72, 7'd75, 7'd80, 7'd81,
    7'd90, 7'd96, 7'd100, 7'd108};

  // Row table searched for the B-matrix index
  localparam logic [14:0] SSC_ROW_TBL [0:71] = '{
    15'd24, 15'd48, 15'd72, 15'd96, 15'd120, 15'd144, 15'd192, 15'd216,
    15'd240, 15'd288, 15'd360, 15'd384, 15'd432, 15'd480, 15'd576,
    15'd600, 15'd648, 15'd720, 15'd768, 15'd864, 15'd960, 15'd1080,
    15'd1152, 15'd1200, 15'd1296, 15'd1440, 15'd1536, 15'd1728, 15'd1800,
    15'd1920, 15'd1944, 15'd2160, 15'd2304, 15'd2400, 15'd2592, 15'd2880,
    15'd3072, 15'd3240, 15'd3456, 15'd3600, 15'd3840, 15'd3888, 15'd4320,
    15'd4608, 15'd4800, 15'd5184, 15'd5400, 15'd5760, 15'd5832, 15'd6144,
    15'd6480, 15'd6912, 15'd7200, 15'd7680, 15'd7776, 15'd8640, 15'd9216,
    15'd9600, 15'd10368, 15'd10800, 15'd11520, 15'd11664, 15'd12288,
    15'd12960, 15'd13824, 15'd14400, 15'd15360, 15'd15552, 15'd17280,
    15'd18432, 15'd19200, 15'd20736};
endpackage : ssc_pkg
`default_nettype wire

// *** test/ssc_props.sv ***
// Checker of the header and symbol stream on the link.
// Assumes instantiation beside the link, signals by name.
`timescale 1ns/1ps
`default_nettype none
module ssc_props (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic valid,
  input wire logic [31:0] data,
  input wire logic last,
  input wire logic ready
);
  logic [2:0] widx;
  logic in_sym;
  logic [2:0] hmod;
  wire hdr = valid && !in_sym;
  wire slot_w = hdr && widx > 3'h2;
  // Header word index and modulation of the packet in flight
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      widx <= 3'h0;
      in_sym <= 1'b0;
      hmod <= 3'h0;
    end else if (hdr) begin
      widx <= (widx == 3'h6) ? 3'h0 : widx + 3'h1;
      in_sym <= (widx == 3'h6);
      if (widx == 3'h1) begin
        hmod <= data[6:4];
      end
    end else if (valid && last) begin
      in_sym <= 1'b0;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  property p_hdr_len;
    hdr && widx == 3'h0 |-> data[6:0] == 7'h06;
  endproperty
  a_hdr_len: assert property (p_hdr_len)
    else $error("header length word wrong");
  property p_hdr_burst;
    hdr && widx == 3'h0 |=> valid [*6];
  endproperty
  a_hdr_burst: assert property (p_hdr_burst)
    else $error("header words not back to back");
  property p_slots;
    hdr && widx == 3'h1 |-> data[22:20] <= 3'h6;
  endproperty
  a_slots: assert property (p_slots)
    else $error("slot count above six");
  property p_slot_size;
    slot_w |-> data[11:0] <= 12'hBF8 && data[15:12] == 4'h0;
  endproperty
  a_slot_size: assert property (p_slot_size)
    else $error("slot symbol count too large");
  property p_unit;
    slot_w |-> (hmod != 3'h1 || data[31:16] <= 16'h3FFF)
      && (hmod != 3'h2 || data[31:16] <= 16'h2AAA)
      && (hmod != 3'h3 || data[31:16] <= 16'h1249);
  endproperty
  a_unit: assert property (p_unit)
    else $error("slot unit value too large");
  property p_cil;
    hdr && widx == 3'h2 |-> (data & 32'hC000C000) == 32'h0;
  endproperty
  a_cil: assert property (p_cil)
    else $error("length word reserved bits set");
  property p_last;
    last |-> valid && in_sym && widx == 3'h0;
  endproperty
  a_last: assert property (p_last)
    else $error("last flag outside symbols");
  property p_ready;
    ready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("device not ready");
endmodule : ssc_props
`default_nettype wire

// *** test/ssc_test.sv ***
// Bench: engine and slicer ends joined by their link.
// Assumes the package, header and interface compiled first.
`timescale 1ns/1ps
`default_nettype none
module soft_slicer_header_config_test;
  logic i_ref_clk, i_arst_n, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  ssc_pkg::ssc_std_type i_radio_std;
  ssc_pkg::ssc_mod_type o_mod;
  logic o_cfg_valid, o_frame_10ms, o_mod_err, o_descr_on, o_split;
  logic o_tdd_sel, o_sb_valid, o_sb_last;
  logic [11:0] o_row_count, o_slot_syms;
  logic [3:0] o_col_count;
  logic [2:0] o_phys_ch, o_num_slots;
  logic [1:0] o_q_format;
  logic [13:0] o_ackn_llr_count, o_rank_llr_count;
  logic [15:0] o_slot_unit;
  logic [127:0] o_sb_data;
  logic [127:0] sb_q[$];
  logic last_q[$];
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  logic [5:0] ridx [0:7] = '{6'h0, 6'h1, 6'h2, 6'h3, 6'h4, 6'h5, 6'h6, 6'h22};
  logic [11:0] rows [0:7] = '{12'h00C, 12'h018, 12'h024, 12'h030, 12'h03C,
    12'h048, 12'h060, 12'h510};
  ssc_if link();
  ssc_host u_ssc_host (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .link(link), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata));
  ssc_dev u_ssc_dev (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .link(link), .i_radio_std(i_radio_std), .o_cfg_valid(o_cfg_valid),
    .o_row_count(o_row_count), .o_col_count(o_col_count),
    .o_phys_ch(o_phys_ch), .o_frame_10ms(o_frame_10ms),
    .o_num_slots(o_num_slots), .o_mod(o_mod), .o_mod_err(o_mod_err),
    .o_descr_on(o_descr_on), .o_split(o_split), .o_tdd_sel(o_tdd_sel),
    .o_q_format(o_q_format), .o_ackn_llr_count(o_ackn_llr_count),
    .o_rank_llr_count(o_rank_llr_count), .o_slot_unit(o_slot_unit),
    .o_slot_syms(o_slot_syms), .o_sb_valid(o_sb_valid),
    .o_sb_data(o_sb_data), .o_sb_last(o_sb_last));
  ssc_props u_ssc_props (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .valid(link.valid), .data(link.data), .last(link.last),
    .ready(link.ready));

  task automatic chk(input string n, input logic [127:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1;
    rv = o_rdata;
  endtask : rd

  task automatic wait_words(input int n);
    for (int i = 0; i < 60 && sb_q.size() < n; i++) begin
      @(posedge i_ref_clk);
      #1;
    end
    chk("word count", sb_q.size(), n);
  endtask : wait_words

  task automatic start_pkt(input logic [31:0] m, c, s0, s1);
    wr(8'h00, m);
    wr(8'h04, c);
    wr(8'h08, s0);
    wr(8'h0C, s1);
    sb_q.delete();
    last_q.delete();
    wr(8'h18, 32'h00000001);
    for (int i = 0; i < 40 && o_cfg_valid !== 1'h1; i++) begin
      @(posedge i_ref_clk);
      #1;
    end
    chk("cfg valid", o_cfg_valid, 1'h1);
  endtask : start_pkt

  task automatic t_lte_split;
    start_pkt({6'h22, 6'h00, 1'h0, 7'h00, 2'h2, 2'h3, 1'h0, 3'h1, 4'hA},
      {2'h0, 14'h0001, 2'h0, 14'h0001}, 32'h0, 32'h0);
    chk("row split", o_row_count, 12'hA20);
    chk("cols", o_col_count, 4'hC);
    chk("split", o_split, 1'h1);
    chk("descr", o_descr_on, 1'h1);
    chk("ack", o_ackn_llr_count, 14'h0001);
    chk("rank", o_rank_llr_count, 14'h0001);
    rd(8'h00);
    chk("bmat", rv[18:12], 7'h2D);
    wr(8'h1C, 32'h40004000);
    wr(8'h1C, 32'h40004000);
    wr(8'h20, 32'h40004000);
    wait_words(1);
    chk("fill lanes", sb_q[0][31:0], 32'h7F7F0000);
    chk("idle lanes", sb_q[0][127:48], 80'h0);
    chk("last", last_q[0], 1'h1);
  endtask : t_lte_split

  task automatic t_modes;
    for (int k = 0; k < 8; k++) begin
      start_pkt({ridx[k], 14'h0000, k[1:0], k[1:0], 1'h0, k[2:0], 4'h8},
        32'h0, 32'h0, 32'h0);
      chk("row", o_row_count, rows[k]);
      chk("cols", o_col_count, 4'h9 + k[1:0]);
      chk("mod", o_mod, k[2:0]);
      chk("mod err", o_mod_err, k > 5);
      chk("q format", o_q_format, k[1:0]);
      chk("split", o_split, 1'h0);
      wr(8'h20, 32'h0);
      wait_words(1);
    end
  endtask : t_modes

  task automatic t_fdd;
    @(posedge i_ref_clk);
    i_radio_std <= ssc_pkg::SSC_STD_WCDMA;
    start_pkt({6'h00, 3'h4, 3'h0, 1'h1, 7'h00, 4'h0, 1'h0, 3'h0, 4'hC},
      32'h0, 32'h0, 32'h0);
    chk("phys ch", o_phys_ch, 3'h4);
    chk("frame", o_frame_10ms, 1'h1);
    chk("tdd", o_tdd_sel, 1'h0);
    chk("descr", o_descr_on, 1'h0);
    wr(8'h20, 32'h7F000100);
    wait_words(1);
    chk("fdd lanes", sb_q[0][15:0], 16'h0001);
  endtask : t_fdd

  task automatic t_tdd;
    start_pkt({6'h00, 3'h0, 3'h7, 1'h0, 7'h00, 4'h0, 1'h0, 3'h1, 4'h5},
      32'h0, 32'h10000001, 32'h48000001);
    rd(8'h00);
    chk("slots read", rv[22:20], 3'h6);
    chk("descr bit", rv[3], 1'h1);
    chk("slots", o_num_slots, 3'h6);
    chk("tdd", o_tdd_sel, 1'h1);
    chk("unit", o_slot_unit, 16'h1000);
    chk("size", o_slot_syms, 12'h001);
    wr(8'h1C, 32'h02000100);
    wait_words(1);
    chk("swap lanes", sb_q[0][15:0], 16'h0102);
    chk("slot flush", last_q[0], 1'h0);
    chk("unit 1", o_slot_unit, 16'h3FFF);
    wr(8'h20, 32'h02000100);
    wait_words(2);
    chk("last", last_q[1], 1'h1);
  endtask : t_tdd

  initial begin
    i_ref_clk = 1'h0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (o_sb_valid === 1'h1) begin
      sb_q.push_back(o_sb_data);
      last_q.push_back(o_sb_last);
    end
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    i_arst_n = 1'h0;
    i_wr = 1'h0;
    i_rd = 1'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_radio_std = ssc_pkg::SSC_STD_LTE;
    repeat (12) @(posedge i_ref_clk);
    i_arst_n <= 1'h1;
    rd(8'h00);
    chk("mode reset", rv, 32'h00000018);
    rd(8'h30);
    chk("unmapped", rv, 32'h0);
    t_lte_split();
    t_modes();
    t_fdd();
    t_tdd();
    summarize();
  end
endmodule : soft_slicer_header_config_test
`default_nettype wire
